// ===== common/trig_seq_defines.vh
// constants for the trigger sequence control block
`ifndef TRIG_SEQ_DEFINES_VH
`define TRIG_SEQ_DEFINES_VH
// sequence numbers
`define SEQ_NUM_TRAN     2'd1
`define SEQ_NUM_ACQ      2'd2
// command codes on cmd_code_in
`define CMD_NONE         3'h0
`define CMD_ABORT        3'h1
`define CMD_INIT_NUM     3'h2
`define CMD_INIT_TRAN    3'h3
`define CMD_INIT_ACQ     3'h4
`define CMD_TRIG_TRAN    3'h5
`define CMD_TRIG_ACQ     3'h6
`define CMD_SET_CONT     3'h7
// measurement function select
`define FUNC_NONE        2'h0
`define FUNC_VOLT        2'h1
`define FUNC_CURR        2'h2
`define FUNC_DVM         2'h3
// trigger source encoding, bus is the only one
`define SRC_BUS          2'h0
// reset value and level width
`define CONT_RESET       1'b0
`define LEVEL_WIDTH      16
`endif

// ===== rtl/seq_arm.v
// one trigger sequence armed flag
`timescale 1ns/10ps
module seq_arm (
  // clock and reset
  input  wire core_clk_in,
  input  wire nrst_in,
  // control
  input  wire abort_in,
  input  wire init_in,
  input  wire trig_in,
  input  wire rearm_in,
  // status
  output reg  armed_out,
  output wire fire_out
);
  assign fire_out = armed_out & trig_in;

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      armed_out <= 1'b0;
    end else if (abort_in) begin
      armed_out <= rearm_in;
    end else if (fire_out) begin
      armed_out <= rearm_in;
    end else if (init_in | rearm_in) begin
      armed_out <= 1'b1;
    end
  end
endmodule // seq_arm

// ===== rtl/trigger_sequence_control.v
// trigger subsystem control: transient and acquire sequences
// Functional notes
// - two sequences: 1 transient (default), 2 acquire, by number or name
// - abort cancels trigger actions, pending levels return to immediate values
// - abort clears the waiting-for-trigger flag
// - with continuous on, abort other than the reset command re-arms and sets waiting flag again
// - abort happens at power-up, state recall and reset command
// - armed sequence acts on its trigger; unarmed sequence discards triggers
// - initiate arms only the named or numbered sequence
// - continuous on keeps the transient sequence permanently armed
// - armed transient bus trigger applies pending current and voltage levels
// - waiting flag is OR of both sequences' waiting states
// - continuous on: re-arm after transient trigger, flag back to one
// - transient source is bus only, reads back and resets to bus
// - armed acquire trigger measures selection and writes acquisition buffer
`timescale 1ns/10ps
`include "trig_seq_defines.vh"
module trigger_sequence_control #(
  parameter LW = `LEVEL_WIDTH
) (
  // clock and reset
  input  wire          core_clk_in,
  input  wire          nrst_in,
  // command port from the interpreter
  input  wire          cmd_valid_in,
  input  wire [2:0]    cmd_code_in,
  input  wire [1:0]    cmd_seq_num_in,
  input  wire          cmd_cont_val_in,
  input  wire          recall_in,
  input  wire          reset_cmd_in,
  input  wire          bus_trig_in,
  // measurement and level settings
  input  wire [1:0]    meas_func_in,
  input  wire [LW-1:0] volt_imm_in,
  input  wire [LW-1:0] curr_imm_in,
  input  wire [LW-1:0] volt_trig_in,
  input  wire [LW-1:0] curr_trig_in,
  // outputs
  output reg  [LW-1:0] volt_out,
  output reg  [LW-1:0] curr_out,
  output reg  [LW-1:0] volt_pend_out,
  output reg  [LW-1:0] curr_pend_out,
  output reg           meas_start_out,
  output reg  [1:0]    meas_func_out,
  output reg           buf_write_out,
  output reg           waiting_for_trigger_flag_out,
  output reg           tran_armed_out,
  output reg           acq_armed_out,
  output reg           cont_out,
  output reg  [1:0]    trig_src_out
);
  reg        cont_r;
  reg        powerup_r;
  reg  [1:0] func_r;
  wire       cmd_abort;
  wire       init_tran;
  wire       init_acq;
  wire       trig_tran;
  wire       trig_acq;
  wire       tran_armed;
  wire       acq_armed;
  wire       tran_fire;
  wire       acq_fire;
  wire       tran_rearm;
  wire       acq_start_ok;

  // power-up, recall and reset command all abort
  assign cmd_abort = (cmd_valid_in & (cmd_code_in == `CMD_ABORT)) | recall_in
                   | reset_cmd_in | powerup_r;
  // sequence 1 is the default when no number is given
  assign init_tran = cmd_valid_in & ((cmd_code_in == `CMD_INIT_TRAN) |
                     ((cmd_code_in == `CMD_INIT_NUM) &
                      (cmd_seq_num_in != `SEQ_NUM_ACQ)));
  assign init_acq  = cmd_valid_in & ((cmd_code_in == `CMD_INIT_ACQ) |
                     ((cmd_code_in == `CMD_INIT_NUM) &
                      (cmd_seq_num_in == `SEQ_NUM_ACQ)));
  // bus trigger line plus trigger command feed the transient source
  assign trig_tran = bus_trig_in | (cmd_valid_in & (cmd_code_in == `CMD_TRIG_TRAN));
  assign trig_acq  = cmd_valid_in & (cmd_code_in == `CMD_TRIG_ACQ);
  // reset command also drops continuous, so no re-arm on that abort
  assign tran_rearm = cont_r & ~reset_cmd_in & ~powerup_r;
  // no function chosen means the trigger cannot measure anything
  assign acq_start_ok = acq_fire & (func_r != `FUNC_NONE);

  seq_arm u_tran (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .abort_in    (cmd_abort),
    .init_in     (init_tran),
    .trig_in     (trig_tran),
    .rearm_in    (tran_rearm),
    .armed_out   (tran_armed),
    .fire_out    (tran_fire)
  );

  seq_arm u_acq (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .abort_in    (cmd_abort),
    .init_in     (init_acq),
    .trig_in     (trig_acq),
    .rearm_in    (1'b0),
    .armed_out   (acq_armed),
    .fire_out    (acq_fire)
  );

  reg  [LW-1:0] volt_pend_nxt;
  reg  [LW-1:0] curr_pend_nxt;
  reg  [LW-1:0] volt_out_nxt;
  reg  [LW-1:0] curr_out_nxt;
  wire          acq_meas_go;
  wire          waiting_nxt;

  // abort in the trigger cycle wins, so no half-started measurement
  assign acq_meas_go = acq_start_ok & ~cmd_abort;
  assign waiting_nxt = tran_armed | acq_armed;

  // power-up strobe: one abort in the first cycle out of reset
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      powerup_r <= 1'b1;
    end else begin
      powerup_r <= 1'b0;
    end
  end

  // continuous setting; reset command forces it back off
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      cont_r   <= `CONT_RESET;
      cont_out <= `CONT_RESET;
    end else begin
      if (reset_cmd_in) begin
        cont_r <= `CONT_RESET;
      end else if (cmd_valid_in & (cmd_code_in == `CMD_SET_CONT)) begin
        cont_r <= cmd_cont_val_in;
      end
      cont_out <= cont_r;
    end
  end

  // only one legal source, so readback is a fixed register
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      trig_src_out <= `SRC_BUS;
    end else begin
      trig_src_out <= `SRC_BUS;
    end
  end

  // pending levels track triggered settings; abort reverts to immediate
  always @* begin
    if (cmd_abort) begin
      volt_pend_nxt = volt_imm_in;
      curr_pend_nxt = curr_imm_in;
    end else begin
      volt_pend_nxt = volt_trig_in;
      curr_pend_nxt = curr_trig_in;
    end
  end

  // applied levels: abort restores immediate, armed trigger applies pending
  always @* begin
    volt_out_nxt = volt_out;
    curr_out_nxt = curr_out;
    if (cmd_abort) begin
      volt_out_nxt = volt_imm_in;
      curr_out_nxt = curr_imm_in;
    end else if (tran_fire) begin
      volt_out_nxt = volt_pend_out;
      curr_out_nxt = curr_pend_out;
    end
  end

  // pending level registers
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      volt_pend_out <= {LW{1'b0}};
      curr_pend_out <= {LW{1'b0}};
    end else begin
      volt_pend_out <= volt_pend_nxt;
      curr_pend_out <= curr_pend_nxt;
    end
  end

  // applied level registers
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      volt_out <= {LW{1'b0}};
      curr_out <= {LW{1'b0}};
    end else begin
      volt_out <= volt_out_nxt;
      curr_out <= curr_out_nxt;
    end
  end

  // measurement start; function held so a later change cannot
  // relabel samples already written
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      func_r         <= `FUNC_NONE;
      meas_start_out <= 1'b0;
      buf_write_out  <= 1'b0;
      meas_func_out  <= `FUNC_NONE;
    end else begin
      func_r         <= meas_func_in;
      meas_start_out <= acq_meas_go;
      buf_write_out  <= acq_meas_go;
      if (acq_start_ok) begin
        meas_func_out <= func_r;
      end
    end
  end

  // flag follows armed state: drops on abort without continuous re-arm, or completion of both
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      tran_armed_out               <= 1'b0;
      acq_armed_out                <= 1'b0;
      waiting_for_trigger_flag_out <= 1'b0;
    end else begin
      tran_armed_out               <= tran_armed;
      acq_armed_out                <= acq_armed;
      waiting_for_trigger_flag_out <= waiting_nxt;
    end
  end
endmodule // trigger_sequence_control

// ===== sim/remote_ctl.sv
// remote controller model driving the command port
`timescale 1ns/10ps
module remote_ctl (
  input  wire       clk_in,
  output reg        vld_out = 1'h0, bt_out = 1'h0, rc_out = 1'h0, rs_out = 1'h0, cv_out = 1'h0,
  output reg  [2:0] code_out = 3'h0,
  output reg  [1:0] seq_out = 2'h0, func_out = 2'h0
);
  // quantity chosen before any acquire trigger
  task sel(input [1:0] f); @(negedge clk_in) func_out <= f; endtask
  // codes 8, 9, a: bus trigger, recall, reset command
  task go(input [3:0] c, input [1:0] s, input v); begin
    @(negedge clk_in);
    {vld_out, code_out, seq_out, cv_out} <= {c < 4'h8, c[2:0], s, v};
    {bt_out, rc_out, rs_out} <= {c == 4'h8, c == 4'h9, c == 4'ha};
    @(negedge clk_in);
    {vld_out, bt_out, rc_out, rs_out} <= 4'h0;
  end endtask
endmodule // remote_ctl

// ===== sim/trig_seq_properties.sv
// port checks for the trigger sequence control block
`timescale 1ns/10ps
`include "trig_seq_defines.vh"
module trig_seq_properties #(parameter LW = 16) (
  input wire          core_clk_in, nrst_in, cmd_valid_in, recall_in, reset_cmd_in,
  input wire          bus_trig_in, meas_start_out, buf_write_out, cont_out,
  input wire          waiting_for_trigger_flag_out, tran_armed_out, acq_armed_out,
  input wire [2:0]    cmd_code_in,
  input wire [1:0]    meas_func_out, trig_src_out,
  input wire [LW-1:0] volt_imm_in, curr_imm_in, volt_out, volt_pend_out, curr_pend_out
);
  // recall and reset command abort as well
  wire ab  = cmd_valid_in && cmd_code_in == `CMD_ABORT || recall_in || reset_cmd_in;
  wire arm = tran_armed_out | acq_armed_out;
  wire waiting_for_trigger_flag = waiting_for_trigger_flag_out;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  AST_WTG_OR: assert property (waiting_for_trigger_flag == arm) else $error("flag not or");
  AST_SRC: assert property (trig_src_out == `SRC_BUS) else $error("source");
  AST_BUF: assert property (buf_write_out == meas_start_out) else $error("buf");
  AST_ABORT: assert property (ab && !cont_out |-> ##2 !arm && !waiting_for_trigger_flag)
    else $error("abort");
  AST_REARM: assert property (ab && cont_out && !reset_cmd_in |-> ##2 tran_armed_out && waiting_for_trigger_flag)
    else $error("rearm");
  AST_PEND: assert property (ab |=> volt_pend_out == $past(volt_imm_in)
    && curr_pend_out == $past(curr_imm_in)) else $error("pending");
  AST_APPLY: assert property (bus_trig_in && !ab ##1 tran_armed_out
    |-> volt_out == $past(volt_pend_out)) else $error("apply");
  AST_MEAS: assert property (meas_start_out |-> meas_func_out != `FUNC_NONE
    && $past(cmd_valid_in && cmd_code_in == `CMD_TRIG_ACQ)) else $error("meas");
endmodule // trig_seq_properties
bind trigger_sequence_control trig_seq_properties #(.LW(LW)) chk_i (.*);

// ===== sim/tb_trigger_sequence_control.sv
// self-checking bench for the trigger sequence control block
`timescale 1ns/10ps
`include "trig_seq_defines.vh"
module tb_trigger_sequence_control;
  reg         clk = 0, nrst = 0;
  reg  [15:0] vi = 0, ci = 0, vt = 0, ct = 0, last = 0;
  reg  [1:0]  f;
  wire        vld, bt, rc, rs, cv, ms, bw, waiting_for_trigger_flag, ta, aa, co;
  wire [2:0]  code;
  wire [1:0]  sq, fn, mf, src;
  wire [15:0] vo, cu, vp, cp;
  integer     err_count = 0, checks_done = 0, cyc = 0, seed = 55721, i;
  initial forever #12.5 clk = ~clk;
  remote_ctl ctl (.clk_in(clk), .vld_out(vld), .bt_out(bt), .rc_out(rc), .rs_out(rs),
    .cv_out(cv), .code_out(code), .seq_out(sq), .func_out(fn));
  trigger_sequence_control uut (.core_clk_in(clk), .nrst_in(nrst), .cmd_valid_in(vld),
    .cmd_code_in(code), .cmd_seq_num_in(sq), .cmd_cont_val_in(cv), .recall_in(rc),
    .reset_cmd_in(rs), .bus_trig_in(bt), .meas_func_in(fn), .volt_imm_in(vi),
    .curr_imm_in(ci), .volt_trig_in(vt), .curr_trig_in(ct), .volt_out(vo), .curr_out(cu),
    .volt_pend_out(vp), .curr_pend_out(cp), .meas_start_out(ms), .meas_func_out(mf),
    .buf_write_out(bw), .waiting_for_trigger_flag_out(waiting_for_trigger_flag), .tran_armed_out(ta),
    .acq_armed_out(aa), .cont_out(co), .trig_src_out(src));
  task w(input integer n); repeat (n) @(negedge clk); endtask
  task chk(input string n, input [31:0] e, g); begin
    checks_done++;
    if (g !== e) begin err_count++; $display("ERROR %s exp %h got %h", n, e, g); end
  end endtask
  task conclude; begin
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  end endtask
  always @(posedge clk) begin cyc++; if (cyc == 2000) begin err_count++; conclude; end end
  initial begin
    w(20); nrst = 1; w(3);
    chk("idle", {`SRC_BUS, 4'h0}, {src, ta, aa, waiting_for_trigger_flag, co});
    for (i = 0; i < 6; i++) begin
      {vt, ct} = $random(seed); {vi, ci} = $random(seed); f = 2'(i % 3 + 1);
      ctl.go(4'h8, 0, 0); w(1); chk("unarmed", last, vo);
      ctl.go(i[0] ? `CMD_INIT_TRAN : `CMD_INIT_NUM, 1, 0); w(2);
      chk("tran arm", 3'h5, {ta, aa, waiting_for_trigger_flag});
      ctl.go(i[1] ? 4'h8 : {1'b0, `CMD_TRIG_TRAN}, 0, 0); w(1); last = vt;
      chk("levels", {vt, ct}, {vo, cu});
      ctl.sel(f); ctl.go(`CMD_TRIG_ACQ, 0, 0);
      chk("acq unarmed", 0, {ms, bw});
      ctl.go(i[0] ? `CMD_INIT_ACQ : `CMD_INIT_NUM, 2, 0); w(2);
      chk("acq arm", 3'h3, {ta, aa, waiting_for_trigger_flag});
      ctl.go(`CMD_TRIG_ACQ, 0, 0);
      chk("meas", {f, 2'h3}, {mf, ms, bw}); w(1);
      chk("acq done", 0, {aa, waiting_for_trigger_flag});
      $display("round %0d done", i);
    end
    ctl.sel(`FUNC_NONE); ctl.go(`CMD_INIT_NUM, 2, 0); ctl.go(`CMD_TRIG_ACQ, 0, 0);
    chk("no func", 0, {ms, bw}); w(2);
    chk("no func arm", 0, {aa, waiting_for_trigger_flag});
    ctl.go(`CMD_SET_CONT, 0, 1); ctl.go(`CMD_INIT_TRAN, 1, 0); w(2);
    chk("cont", 3'h7, {co, ta, waiting_for_trigger_flag});
    {vt, ct} = $random(seed); ctl.go(4'h8, 0, 0); w(2);
    chk("cont trig", {vt, 2'h3}, {vo, ta, waiting_for_trigger_flag});
    {vi, ci} = $random(seed); ctl.go(`CMD_ABORT, 0, 0);
    chk("pend", {vi, ci}, {vp, cp}); w(2);
    chk("abort rearm", 2'h3, {ta, waiting_for_trigger_flag});
    ctl.go(4'ha, 0, 0); w(2); chk("reset cmd", 0, {co, ta, aa, waiting_for_trigger_flag});
    ctl.go(`CMD_INIT_ACQ, 0, 0); ctl.go(`CMD_ABORT, 0, 0); w(2);
    chk("abort", 0, {aa, waiting_for_trigger_flag});
    ctl.go(`CMD_INIT_TRAN, 1, 0); ctl.go(4'h9, 0, 0); w(2);
    chk("recall", 0, {ta, waiting_for_trigger_flag});
    $display("continuous and abort done");
    conclude;
  end
endmodule // tb_trigger_sequence_control
